// [design/psram_host.sv]
// Host controller driving an asynchronous 1M x 16 pseudo-static RAM through its pins
`timescale 1ns/100ps
`default_nettype none
module psram_host
   import psram_host_pkg::*;
#(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 16
) (
   // Clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              reset_n_i,
   // User request
   input  wire logic              req_valid_i,
   input  wire logic              req_write_i,
   input  wire logic [ADDR_W-1:0] req_addr_i,
   input  wire logic [DATA_W-1:0] req_wdata_i,
   input  wire logic [1:0]        req_lanes_i,
   output logic                   req_ready_o,
   output logic                   rsp_valid_o,
   output logic [DATA_W-1:0]      rsp_rdata_o,
   // Memory pins
   output logic [ADDR_W-1:0]      mem_addr_o,
   output logic                   chip_select_low_n_o,
   output logic                   chip_select_high_o,
   output logic                   write_strobe_n_o,
   output logic                   output_gate_n_o,
   output logic                   upper_lane_enable_n_o,
   output logic                   lower_lane_enable_n_o,
   input  wire logic [DATA_W-1:0] mem_data_i,
   output logic [DATA_W-1:0]      mem_data_o,
   output logic                   mem_data_oe_o
);

   // Only the 20-bit address and 16-bit data pinout is served
   if (ADDR_W != 20 || DATA_W != 16) begin : g_param_check
      $error("psram_host supports only 20-bit address and 16-bit data");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      state_e              st;
      logic [CNT_W-1:0]    cnt;
      logic                wr;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic [1:0]          lanes;
      logic                cs_n;
      logic                cs_h;
      logic                we_n;
      logic                oe_n;
      logic                ub_n;
      logic                lb_n;
      logic                doe;
      logic                ready;
      logic                rvalid;
      logic [DATA_W-1:0]   rdata;
   } ctl_s;

   localparam logic [CNT_W-1:0] CYC_CYCLE  = CNT_W'(T_CYCLE_CYC);
   localparam logic [CNT_W-1:0] CYC_WEND   = CNT_W'(T_WRITE_END_CYC);
   localparam logic [CNT_W-1:0] CYC_DSETUP = CNT_W'(T_DATA_SETUP_CYC);
   localparam logic [CNT_W-1:0] CYC_DESEL  = CNT_W'(T_DESELECT_CYC);
   localparam logic [CNT_W-1:0] CYC_HIZ    = CNT_W'(T_HIZ_CYC);
   localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);

   ctl_s ctl_reg;
   ctl_s ctl_next;

   always_comb begin
      ctl_next = ctl_reg;
      ctl_next.rvalid = 1'b0;
      case (ctl_reg.st)
         ST_IDLE: begin
            // Fully deselected, lanes high: standby between accesses
            if (req_valid_i && ctl_reg.ready) begin
               ctl_next.ready = 1'b0;
               ctl_next.wr    = req_write_i;
               ctl_next.addr  = req_addr_i;
               ctl_next.wdata = req_wdata_i;
               ctl_next.lanes = req_lanes_i;
               ctl_next.st    = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // Address settled one cycle before select goes active
            ctl_next.cs_n = 1'b0;
            ctl_next.cs_h = 1'b1;
            // Lanes go active with select, 14 cycles ahead of write end
            ctl_next.ub_n = ~ctl_reg.lanes[1];
            ctl_next.lb_n = ~ctl_reg.lanes[0];
            ctl_next.cnt  = CNT_ONE;
            if (ctl_reg.wr) begin
               ctl_next.oe_n = 1'b1;
               ctl_next.st   = ST_WRITE;
            end else begin
               ctl_next.oe_n = 1'b0;
               ctl_next.st   = ST_READ;
            end
         end
         ST_READ: begin
            // Full-length read keeps the refresh window satisfied
            ctl_next.cnt = ctl_reg.cnt + CNT_ONE;
            if (ctl_reg.cnt >= CYC_CYCLE) begin
               ctl_next.rdata  = mem_data_i;
               ctl_next.rvalid = 1'b1;
               ctl_next.cs_n   = 1'b1;
               ctl_next.cs_h   = 1'b0;
               ctl_next.oe_n   = 1'b1;
               ctl_next.ub_n   = 1'b1;
               ctl_next.lb_n   = 1'b1;
               ctl_next.cnt    = CNT_ONE;
               ctl_next.st     = ST_RECOV;
            end
         end
         ST_WRITE: begin
            ctl_next.cnt = ctl_reg.cnt + CNT_ONE;
            // Bus released until device output has surely turned off
            if (ctl_reg.cnt == CYC_HIZ) begin
               ctl_next.we_n = 1'b0;
            end
            if (ctl_reg.cnt == CYC_HIZ + CNT_ONE) begin
               ctl_next.doe = 1'b1;
            end
            // End write by dropping strobe, select and lanes together
            if (ctl_reg.cnt >= CYC_HIZ + CYC_DSETUP + CNT_ONE && ctl_reg.cnt >= CYC_CYCLE) begin
               ctl_next.we_n = 1'b1;
               ctl_next.cs_n = 1'b1;
               ctl_next.cs_h = 1'b0;
               ctl_next.ub_n = 1'b1;
               ctl_next.lb_n = 1'b1;
               ctl_next.cnt  = CNT_ONE;
               ctl_next.st   = ST_RECOV;
            end
         end
         ST_RECOV: begin
            // Data driver released a cycle after write end
            ctl_next.doe = 1'b0;
            ctl_next.cnt = ctl_reg.cnt + CNT_ONE;
            // Deselect gap before the next access
            if (ctl_reg.cnt >= CYC_DESEL) begin
               ctl_next.ready = 1'b1;
               ctl_next.st    = ST_IDLE;
            end
         end
         default: begin
            ctl_next.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctl_reg       <= '0;
         ctl_reg.st    <= ST_IDLE;
         ctl_reg.cs_n  <= 1'b1;
         ctl_reg.we_n  <= 1'b1;
         ctl_reg.oe_n  <= 1'b1;
         ctl_reg.ub_n  <= 1'b1;
         ctl_reg.lb_n  <= 1'b1;
         ctl_reg.ready <= 1'b1;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign req_ready_o           = ctl_reg.ready;
   assign rsp_valid_o           = ctl_reg.rvalid;
   assign rsp_rdata_o           = ctl_reg.rdata;
   assign mem_addr_o            = ctl_reg.addr;
   assign chip_select_low_n_o   = ctl_reg.cs_n;
   assign chip_select_high_o    = ctl_reg.cs_h;
   assign write_strobe_n_o      = ctl_reg.we_n;
   assign output_gate_n_o       = ctl_reg.oe_n;
   assign upper_lane_enable_n_o = ctl_reg.ub_n;
   assign lower_lane_enable_n_o = ctl_reg.lb_n;
   assign mem_data_o            = ctl_reg.wdata;
   assign mem_data_oe_o         = ctl_reg.doe;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   wire sel_act = !ctl_reg.cs_n && ctl_reg.cs_h;
   wire wr_act  = sel_act && !ctl_reg.we_n && !(ctl_reg.ub_n && ctl_reg.lb_n);

   property p_addr_stable_in_write;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      wr_act |-> $stable(mem_addr_o);
   endproperty
   a_addr_stable_in_write: assert property (p_addr_stable_in_write) else $error("address moved during write");

   property p_data_setup;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (wr_act && !$past(wr_act, 1) ) |-> ##0 1'b1 ##1 (mem_data_oe_o [*5]);
   endproperty
   a_data_setup: assert property (p_data_setup) else $error("write data setup too short");

   property p_data_hold;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      ($fell(wr_act)) |-> mem_data_oe_o && $stable(mem_data_o);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("write data not held after write end");

   property p_addr_setup;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $fell(wr_act) |-> $past(sel_act, 12) && $stable(mem_addr_o) && ($past(mem_addr_o, 12) == mem_addr_o);
   endproperty
   a_addr_setup: assert property (p_addr_setup) else $error("select or address setup short at write end");

   property p_no_contention;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      mem_data_oe_o |-> (output_gate_n_o && !write_strobe_n_o) || !sel_act;
   endproperty
   a_no_contention: assert property (p_no_contention) else $error("host drives bus while device may drive");

   property p_lane_setup;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $fell(wr_act) |-> $past(!(upper_lane_enable_n_o && lower_lane_enable_n_o), 12);
   endproperty
   a_lane_setup: assert property (p_lane_setup) else $error("lane enable setup short at write end");

   sequence s_deselect_gap;
      !sel_act [*3];
   endsequence
   property p_deselect_gap;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $fell(sel_act) |-> s_deselect_gap;
   endproperty
   a_deselect_gap: assert property (p_deselect_gap) else $error("deselect gap under 15 ns");

   property p_lanes_hold;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(upper_lane_enable_n_o && lower_lane_enable_n_o) |=> upper_lane_enable_n_o && lower_lane_enable_n_o;
   endproperty
   a_lanes_hold: assert property (p_lanes_hold) else $error("lanes re-enabled within 5 ns");

   property p_cycle_bound;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(sel_act) |-> ##[14:40] !sel_act;
   endproperty
   a_cycle_bound: assert property (p_cycle_bound) else $error("access cycle length out of range");

   property p_addr_before_select;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(sel_act) |-> $stable(mem_addr_o);
   endproperty
   a_addr_before_select: assert property (p_addr_before_select) else $error("address moved with select");

endmodule
`default_nettype wire

// [design/psram_host_pkg.sv]
// Package with timing constants and state codes for the pseudo-static RAM host controller
package psram_host_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS   = 5000;
   localparam int T_CYCLE_NS      = 70;      // read and write cycle minimum
   localparam int T_WRITE_END_NS  = 60;      // address, select and lane setup to write end
   localparam int T_DATA_SETUP_NS = 25;
   localparam int T_DESELECT_NS   = 15;
   localparam int T_HIZ_NS        = 25;      // device output turn-off after gate or strobe
   localparam int T_CYCLE_CYC     = (T_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_WRITE_END_CYC = (T_WRITE_END_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_DATA_SETUP_CYC = (T_DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_DESELECT_CYC  = (T_DESELECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_HIZ_CYC       = (T_HIZ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W           = 5;

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_SETUP  = 5'b00010,
      ST_READ   = 5'b00100,
      ST_WRITE  = 5'b01000,
      ST_RECOV  = 5'b10000
   } state_e;
endpackage

// [bench/psram_device_model.sv]
// Behavioural pseudo-static RAM device as seen from the host pins
`timescale 1ns/100ps
`default_nettype none
module psram_device_model (
   // Device pins
   input  wire logic [19:0] addr_i,
   input  wire logic        chip_select_low_n_i,
   input  wire logic        chip_select_high_i,
   input  wire logic        write_strobe_n_i,
   input  wire logic        output_gate_n_i,
   input  wire logic        upper_lane_enable_n_i,
   input  wire logic        lower_lane_enable_n_i,
   input  wire logic [15:0] bus_i,
   input  wire logic        host_oe_i,
   output logic [15:0]      dev_data_o,
   output logic [1:0]       dev_en_o,
   // Bench control and status
   input  wire logic [7:0]  acc_ns_i,
   output var int           viol_o
);
   logic [15:0] mem [logic [19:0]];
   logic [19:0] wr_addr;
   logic [15:0] wr_data;
   logic [1:0]  wr_lanes;
   realtime     t_addr, t_data, t_lane, t_free;
   wire logic       sel    = !chip_select_low_n_i && chip_select_high_i;
   wire logic [1:0] lanes  = {!upper_lane_enable_n_i, !lower_lane_enable_n_i};
   wire logic       active = sel && (lanes != 2'h0);
   wire logic       wr_act = active && !write_strobe_n_i;
   wire logic       rd_act = active && write_strobe_n_i && !output_gate_n_i;

   initial begin
      dev_data_o = 16'hA5A5;
      dev_en_o = 2'h0;
      viol_o = 0;
      t_free = -100.0;
   end
   // -------------------------------------------------------------
   // Host timing checks
   // -------------------------------------------------------------
   always @(addr_i) begin
      if (wr_act) viol_o++;
      t_addr = $realtime;
   end
   always @(bus_i or host_oe_i) t_data = $realtime;
   always @(host_oe_i or dev_en_o) if (host_oe_i && dev_en_o != 2'h0) viol_o++;
   always @(negedge active) t_free = $realtime;
   always @(posedge active) begin
      t_lane = $realtime;
      if ($realtime - t_free < 15.0) viol_o++;
      if (!output_gate_n_i && $realtime - t_addr <= 0.0) viol_o++;
   end
   // -------------------------------------------------------------
   // Write path
   // -------------------------------------------------------------
   // Decoded inline so a falling enable never latches a stale lane set
   always @* begin
      if (!chip_select_low_n_i && chip_select_high_i && !write_strobe_n_i &&
          !(upper_lane_enable_n_i && lower_lane_enable_n_i)) begin
         wr_addr = addr_i;
         wr_data = bus_i;
         wr_lanes = {!upper_lane_enable_n_i, !lower_lane_enable_n_i};
      end
   end
   always @(negedge wr_act) begin
      if ($realtime > 0.0) begin
         if ($realtime - t_data < 25.0) viol_o++;
         if ($realtime - t_addr < 60.0) viol_o++;
         if ($realtime - t_lane < 60.0) viol_o++;
         if (wr_lanes[0]) mem[wr_addr][7:0] = wr_data[7:0];
         if (wr_lanes[1]) mem[wr_addr][15:8] = wr_data[15:8];
      end
   end
   // -------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------
   always @(posedge rd_act) begin
      #(acc_ns_i);
      if (rd_act) begin
         dev_en_o = lanes;
         dev_data_o = {lanes[1] ? mem[addr_i][15:8] : ~dev_data_o[15:8],
                       lanes[0] ? mem[addr_i][7:0] : ~dev_data_o[7:0]};
      end
   end
   // Released lines show inverted data, never the last value
   always @(negedge rd_act) begin
      #5;
      dev_en_o = 2'h0;
      dev_data_o = ~dev_data_o;
   end
endmodule
`default_nettype wire

// [bench/psram_host_tb.sv]
// Self-checking testbench for the pseudo-static RAM host controller
`timescale 1ns/100ps
`default_nettype none
module psram_host_tb;
   import psram_host_pkg::*;
   logic        core_clk, reset_n, req_valid, req_write, req_ready, rsp_valid;
   logic [19:0] req_addr, mem_addr;
   logic [15:0] req_wdata, rsp_rdata, mem_dout, dev_data;
   logic [1:0]  req_lanes, dev_en;
   logic        cs_low_n, cs_high, we_n, oe_n, ub_n, lb_n, mem_oe;
   logic [7:0]  acc_ns;
   int          viol, bad_count, checks, cycles;
   wire logic [15:0] mem_bus = mem_oe ? mem_dout : dev_data;

   psram_host DUT (.core_clk_i(core_clk), .reset_n_i(reset_n), .req_valid_i(req_valid),
      .req_write_i(req_write), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
      .req_lanes_i(req_lanes), .req_ready_o(req_ready), .rsp_valid_o(rsp_valid),
      .rsp_rdata_o(rsp_rdata), .mem_addr_o(mem_addr), .chip_select_low_n_o(cs_low_n),
      .chip_select_high_o(cs_high), .write_strobe_n_o(we_n), .output_gate_n_o(oe_n),
      .upper_lane_enable_n_o(ub_n), .lower_lane_enable_n_o(lb_n), .mem_data_i(mem_bus),
      .mem_data_o(mem_dout), .mem_data_oe_o(mem_oe));
   psram_device_model dev (.addr_i(mem_addr), .chip_select_low_n_i(cs_low_n),
      .chip_select_high_i(cs_high), .write_strobe_n_i(we_n), .output_gate_n_i(oe_n),
      .upper_lane_enable_n_i(ub_n), .lower_lane_enable_n_i(lb_n), .bus_i(mem_bus),
      .host_oe_i(mem_oe), .dev_data_o(dev_data), .dev_en_o(dev_en), .acc_ns_i(acc_ns),
      .viol_o(viol));
   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Valid is held until an edge sees ready high
   task automatic issue(input logic wr, input logic [19:0] a, input logic [15:0] d, input logic [1:0] ln);
      @(posedge core_clk);
      req_valid <= 1'h1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      req_lanes <= ln;
      do @(posedge core_clk); while (req_ready !== 1'h1);
      req_valid <= 1'h0;
   endtask
   task automatic do_read(input logic [19:0] a, input logic [1:0] ln, input logic [15:0] exp);
      int n;
      logic [15:0] m;
      issue(1'h0, a, 16'h0000, ln);
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (rsp_valid !== 1'h1 && n < 40);
      m = {{8{ln[1]}}, {8{ln[0]}}};
      chk(n, 1 + T_CYCLE_CYC, "read latency");
      chk(rsp_rdata & m, exp & m, "read data");
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_idle;
      chk({cs_low_n, cs_high, we_n, oe_n, ub_n, lb_n, mem_oe, req_ready}, 8'hBD, "idle pins");
      $display("Test idle done");
   endtask
   task automatic t_lanes;
      issue(1'h1, 20'h80001, 16'h1234, 2'h3);
      do_read(20'h80001, 2'h3, 16'h1234);
      issue(1'h1, 20'h80001, 16'hABCD, 2'h1);
      do_read(20'h80001, 2'h3, 16'h12CD);
      issue(1'h1, 20'h80001, 16'h5566, 2'h2);
      do_read(20'h80001, 2'h3, 16'h55CD);
      do_read(20'h80001, 2'h1, 16'h55CD);
      do_read(20'h80001, 2'h2, 16'h55CD);
      $display("Test lanes done");
   endtask
   task automatic t_slow;
      acc_ns = 8'h45;
      issue(1'h1, 20'hFFFFF, 16'hC001, 2'h3);
      issue(1'h1, 20'h00000, 16'h3FFE, 2'h3);
      do_read(20'hFFFFF, 2'h3, 16'hC001);
      do_read(20'h00000, 2'h3, 16'h3FFE);
      acc_ns = 8'h14;
      $display("Test slow device done");
   endtask
   task automatic t_refused;
      issue(1'h1, 20'h00010, 16'h0F0F, 2'h3);
      @(posedge core_clk);
      req_valid <= 1'h1;
      req_wdata <= 16'hFFFF;
      @(posedge core_clk);
      chk(req_ready, 1'h0, "busy ready");
      req_valid <= 1'h0;
      issue(1'h1, 20'h00010, 16'h7777, 2'h0);
      do_read(20'h00010, 2'h3, 16'h0F0F);
      $display("Test refused and no-lane done");
   endtask
   // -------------------------------------------------------------
   // Clock, reset, sequence and timeout
   // -------------------------------------------------------------
   initial begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         $display("Error at %0t: run timed out", $time);
         tally_and_finish();
      end
   end
   initial begin
      reset_n = 1'h0;
      req_valid = 1'h0;
      req_write = 1'h0;
      req_addr = 20'h00000;
      req_wdata = 16'h0000;
      req_lanes = 2'h0;
      acc_ns = 8'h14;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'h1;
      @(posedge core_clk);
      #1;
      t_idle();
      t_lanes();
      t_slow();
      t_refused();
      chk(viol, 0, "pin timing");
      tally_and_finish();
   end
endmodule
`default_nettype wire
